// *** logic/fsc_setup_reg.sv ***
// system setup register with decoded configuration outputs
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module fsc_setup_reg
(
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic [fsc_pkg::ADDR_W-1:0] addr,
	input  wire logic [15:0]               wrData,
	input  wire logic                      wrStb,
	input  wire logic                      rdStb,
	output logic      [15:0]               rdData,
	input  wire logic                      bootGuardIn,
	input  wire logic                      alertBusy,
	input  wire logic                      readyIn,
	output logic                           readTimingSelect,
	output logic      [2:0]                burstFirstLatency,
	output logic                           latencyValid,
	output logic      [5:0]                burstWordCount,
	output logic                           burstCountValid,
	output logic                           eccBypass,
	output logic                           readyAlignData,
	output logic                           readyPinOut,
	output logic                           readyPinOe,
	output logic                           alertPinOut,
	output logic                           alertPinOe
);
	import fsc_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [15:0] setup_r, setup_nxt;
	logic [15:0] rdData_r, rdData_nxt;
	logic [2:0]  guardSync_r, guardSync_nxt;
	logic        guard_r, guard_nxt;
	logic        hit;

	assign hit = (addr == SETUP_ADDR);

	always_comb begin
		setup_nxt = setup_r;
		if (wrStb && hit) begin
			// only bits 15:4 take host data
			setup_nxt = (wrData & SETUP_WMASK)
				| (setup_r & ~SETUP_WMASK); // see R6 see R11
		end
		guardSync_nxt = {guardSync_r[1:0], bootGuardIn};
		guard_nxt = guard_r;
		if (guardSync_r[2] == guardSync_r[1]) begin
			guard_nxt = guardSync_r[2];
		end
		rdData_nxt = 16'h0000;
		if (rdStb && hit) begin
			rdData_nxt = {setup_r[15:4], 3'h0, guard_r}; // see R6
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			setup_r     <= SETUP_RESET; // see R1
			rdData_r    <= 16'h0000;
			guardSync_r <= 3'h0;
			guard_r     <= 1'b0;
		end else begin
			setup_r     <= setup_nxt;
			rdData_r    <= rdData_nxt;
			guardSync_r <= guardSync_nxt;
			guard_r     <= guard_nxt;
		end
	end

	assign rdData = rdData_r;

	////////////////////////////////////////////////////////////////////
	// configuration decode
	always_comb begin
		readTimingSelect  = setup_r[MODE_SEL_BIT]; // see R2
		burstFirstLatency = setup_r[LAT_HI:LAT_LO]; // see R3
		latencyValid      = setup_r[LAT_HI:LAT_LO] >= LAT_MIN_CODE;
		eccBypass         = setup_r[ECC_BIT]; // see R7
		readyAlignData    = setup_r[RDYCONF_BIT]; // see R10
		burstCountValid   = 1'b1;
		case (setup_r[WCNT_HI:WCNT_LO]) // see R4
			3'h0: burstWordCount = BURST_CONT;
			3'h1: burstWordCount = 6'h04;
			3'h2: burstWordCount = 6'h08;
			3'h3: burstWordCount = 6'h10;
			3'h4: burstWordCount = 6'h20;
			default: begin
				burstWordCount  = BURST_CONT;
				burstCountValid = 1'b0;
			end
		endcase
		if (!setup_r[MODE_SEL_BIT]) begin
			// async reads ignore burst length
			burstWordCount = BURST_CONT; // see R5
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin drive, high impedance until buffers enabled
	always_comb begin
		readyPinOe  = setup_r[PIN_OE_BIT]; // see R9
		alertPinOe  = setup_r[PIN_OE_BIT]; // see R9
		readyPinOut = readyIn ~^ setup_r[READY_POL_BIT]; // see R8
		alertPinOut = (!alertBusy) ~^ setup_r[ALERT_POL_BIT]; // see R9
	end

	////////////////////////////////////////////////////////////////////
	property p_reset_value;
		@(posedge mclk) $fell(rst) |-> setup_r == SETUP_RESET;
	endproperty
	a_reset_value: assert property (p_reset_value) // see R1
		else $error("setup not at reset value");

	property p_write_takes;
		@(posedge mclk) disable iff (rst)
		wrStb && hit |=> setup_r[15:4] == $past(wrData[15:4]);
	endproperty
	a_write_takes: assert property (p_write_takes) // see R6
		else $error("write not stored");

	property p_low_fixed;
		@(posedge mclk) disable iff (rst)
		rdStb && hit |=> rdData[3:0] == {3'h0, $past(guard_r)};
	endproperty
	a_low_fixed: assert property (p_low_fixed) // see R11
		else $error("reserved or status bits wrong");

	property p_read_word;
		@(posedge mclk) disable iff (rst)
		rdStb && hit |=> rdData[15:4] == $past(setup_r[15:4])
			&& rdData[3:1] == 3'h0;
	endproperty
	a_read_word: assert property (p_read_word) // see R6
		else $error("read data wrong");

	property p_mode;
		@(posedge mclk) readTimingSelect == setup_r[15];
	endproperty
	a_mode: assert property (p_mode) // see R2
		else $error("read mode mismatch");

	property p_latency;
		@(posedge mclk) latencyValid == (setup_r[14:12] > 3'h2);
	endproperty
	a_latency: assert property (p_latency) // see R3
		else $error("latency valid wrong");

	property p_burst;
		@(posedge mclk) setup_r[15] && setup_r[11:9] == 3'h3
			|-> burstWordCount == 6'h10;
	endproperty
	a_burst: assert property (p_burst) // see R4
		else $error("burst count wrong");

	property p_async_cont;
		@(posedge mclk) !setup_r[15] |-> burstWordCount == 6'h00;
	endproperty
	a_async_cont: assert property (p_async_cont) // see R5
		else $error("async burst not continuous");

	property p_ecc;
		@(posedge mclk) eccBypass == setup_r[8];
	endproperty
	a_ecc: assert property (p_ecc) // see R7
		else $error("ecc bypass mismatch");

	property p_ready_pol;
		@(posedge mclk) readyPinOe && readyIn
			|-> readyPinOut == setup_r[7];
	endproperty
	a_ready_pol: assert property (p_ready_pol) // see R8
		else $error("ready polarity wrong");

	property p_hiz;
		@(posedge mclk) disable iff (rst)
		wrStb && hit && !wrData[5] |=> !readyPinOe && !alertPinOe;
	endproperty
	a_hiz: assert property (p_hiz) // see R9
		else $error("pins driven while disabled");

	property p_rdy_conf;
		@(posedge mclk) readyAlignData == setup_r[4];
	endproperty
	a_rdy_conf: assert property (p_rdy_conf) // see R10
		else $error("ready timing mismatch");

	property p_read_idle;
		@(posedge mclk) disable iff (rst)
		!(rdStb && hit) |=> rdData == 16'h0000;
	endproperty
	a_read_idle: assert property (p_read_idle) // see R6
		else $error("read data not cleared");

	property p_other_addr;
		@(posedge mclk) disable iff (rst)
		wrStb && !hit |=> setup_r == $past(setup_r);
	endproperty
	a_other_addr: assert property (p_other_addr) // see R6
		else $error("write to other address stored");

	property p_guard_hold;
		@(posedge mclk) disable iff (rst)
		guardSync_r[2] != guardSync_r[1]
			|=> guard_r == $past(guard_r);
	endproperty
	a_guard_hold: assert property (p_guard_hold) // see R6
		else $error("guard status took unsettled input");

	property p_count_valid;
		@(posedge mclk) burstCountValid == (setup_r[11:9] < 3'h5);
	endproperty
	a_count_valid: assert property (p_count_valid) // see R4
		else $error("burst count valid wrong");

	property p_burst_max;
		@(posedge mclk) setup_r[15] && setup_r[11:9] == 3'h4
			|-> burstWordCount == 6'h20;
	endproperty
	a_burst_max: assert property (p_burst_max) // see R4
		else $error("longest burst count wrong");

	property p_alert_pol;
		@(posedge mclk) alertPinOe && !alertBusy
			|-> alertPinOut == setup_r[6];
	endproperty
	a_alert_pol: assert property (p_alert_pol) // see R9
		else $error("alert polarity wrong");

	c_write: cover property (@(posedge mclk) wrStb && hit);
	c_read: cover property (@(posedge mclk) rdStb && hit);
	c_sync: cover property (@(posedge mclk) readTimingSelect);
	c_pins: cover property (@(posedge mclk) readyPinOe);
endmodule

// *** pkg/fsc_pkg.sv ***
// constants for the flash system setup register block
//
// Overview of operation
// R1: reset loads setup register with 40c0
// R2: bit 15 picks async or sync reads
// R3: bits 14:12 set first burst word latency
// R4: bits 11:9 decode burst word count
// R5: burst count applies to sync reads only
// R6: bits 15:4 writable, 3:1 zero, 0 status
// R7: bit 8 set bypasses error correction
// R8: bit 7 sets ready pin polarity
// R9: pins high impedance until bit 5 set
// R10: bit 4 sets ready timing vs data
// R11: writes to reserved, status bits ignored
package fsc_pkg;
	localparam int          ADDR_W         = 16;
	localparam logic [15:0] SETUP_ADDR     = 16'hf221;
	localparam logic [15:0] SETUP_RESET    = 16'h40c0;
	localparam logic [15:0] SETUP_WMASK    = 16'hfff0;
	localparam int          MODE_SEL_BIT   = 15;
	localparam int          LAT_HI         = 14;
	localparam int          LAT_LO         = 12;
	localparam int          WCNT_HI        = 11;
	localparam int          WCNT_LO        = 9;
	localparam int          ECC_BIT        = 8;
	localparam int          READY_POL_BIT  = 7;
	localparam int          ALERT_POL_BIT  = 6;
	localparam int          PIN_OE_BIT     = 5;
	localparam int          RDYCONF_BIT    = 4;
	localparam int          GUARD_BIT      = 0;
	localparam logic [2:0]  LAT_MIN_CODE   = 3'h3;
	localparam logic [5:0]  BURST_CONT     = 6'h00;
endpackage

// *** tb/fsc_host_model.sv ***
// host bus master model for the setup register port
`timescale 1ns/1ps
module fsc_host_model (
	input  wire logic        mclk,
	output logic      [15:0] addr,
	output logic      [15:0] wrData,
	output logic             wrStb,
	output logic             rdStb,
	input  wire logic [15:0] rdData
);
	initial begin
		addr = 16'h0000;
		wrData = 16'h0000;
		wrStb = 1'b0;
		rdStb = 1'b0;
	end
	// released lines show the inverse, not the last value
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
		addr <= ~a;
		wrData <= ~d;
	endtask
	task rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		addr <= ~a;
		@(posedge mclk);
		d = rdData;
	endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the setup register
`timescale 1ns/1ps
module tb;
	import fsc_pkg::*;
	logic mclk = 0, rst = 1, guard = 0, rdyIn = 0, busy = 0;
	logic [15:0] addr, wd, rdData, d, w;
	logic ws, rs, rts, lv, bv, ecc, ral, rpo, rpe, apo, ape;
	logic [2:0] lat;
	logic [3:0] pe;
	logic [5:0] bwc;
	int n_mismatch = 0, checks = 0, cyc = 0;
	// write value, burst count, latency ok, count ok
	logic [23:0] rows [7] = '{{16'hc000, 6'h00, 2'b11},
		{16'hb20f, 6'h04, 2'b11}, {16'hd510, 6'h08, 2'b11},
		{16'he620, 6'h10, 2'b11}, {16'hf880, 6'h20, 2'b11},
		{16'h2a00, 6'h00, 2'b00}, {16'h3800, 6'h00, 2'b11}};
	always #10 mclk = ~mclk;
	fsc_host_model host_u (.mclk(mclk), .addr(addr), .wrData(wd),
		.wrStb(ws), .rdStb(rs), .rdData(rdData));
	fsc_setup_reg dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wd),
		.wrStb(ws), .rdStb(rs), .rdData(rdData), .bootGuardIn(guard),
		.alertBusy(busy), .readyIn(rdyIn), .readTimingSelect(rts),
		.burstFirstLatency(lat), .latencyValid(lv), .burstWordCount(bwc),
		.burstCountValid(bv), .eccBypass(ecc), .readyAlignData(ral),
		.readyPinOut(rpo), .readyPinOe(rpe), .alertPinOut(apo),
		.alertPinOe(ape));
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task test_done;
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done;
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		chk({rpe, ape, rts, lat, bwc} === {3'h0, 3'h4, 6'h00},
			"reset");
		host_u.rd(SETUP_ADDR, d);
		chk(d === SETUP_RESET, "reset value");
		guard <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 7; i++) begin
			w = rows[i][23:8];
			host_u.wr(SETUP_ADDR, w);
			host_u.rd(SETUP_ADDR, d);
			chk(d === ((w & SETUP_WMASK) | 16'h0001),
				"readback");
			chk({rts, lat} === w[15:12], "mode, latency");
			chk({ecc, ral} === {w[8], w[4]}, "ecc, timing");
			chk({bwc, lv, bv} === rows[i][7:0], "burst");
		end
		host_u.wr(16'hf222, 16'h0000);
		host_u.rd(SETUP_ADDR, d);
		chk(d === 16'h3801, "other address write");
		host_u.rd(16'hf222, d);
		chk(d === 16'h0000, "other address read");
		for (int i = 0; i < 8; i++) begin
			rdyIn <= i[0];
			busy <= ~i[0];
			host_u.wr(SETUP_ADDR, {8'h40, i[2], i[1], 1'b1, 5'h00});
			@(posedge mclk);
			pe = {2'b11, i[0] ~^ i[2], i[0] ~^ i[1]};
			chk({rpe, ape, rpo, apo} === pe, "pins");
		end
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		host_u.rd(SETUP_ADDR, d);
		// guard bit reads 0 until resynced
		chk({d, rpe, ape} === {SETUP_RESET, 2'b00}, "second reset");
		repeat (2) @(posedge mclk);
		host_u.rd(SETUP_ADDR, d);
		chk(d === (SETUP_RESET | 16'h0001), "guard after reset");
		test_done;
	end
endmodule
